// ==== pkg/rrsa_defs.svh ====
/*
 Constants of the serial RTC memory front end: map, control bits, time base.
 Assumes it is included by bare name from design files of this block.
*/
`ifndef RRSA_DEFS_SVH
`define RRSA_DEFS_SVH
// ==========================================================
// memory map
`define RRSA_MEM_DEPTH  256
`define RRSA_CTRL_ADDR  8'h00
`define RRSA_CNT_TOP    8'h07
`define RRSA_FREE_BASE  8'h10
`define RRSA_SLV_BASE   6'h28
`define RRSA_CTRL_RST   8'h00
// ==========================================================
// control and counter bit positions
`define RRSA_CB_STOP    7
`define RRSA_CB_MODE_HI 5
`define RRSA_CB_MODE_LO 4
`define RRSA_CB_MASK    3
`define RRSA_CB_ALARM   2
`define RRSA_CB_TFLAG   0
`define RRSA_HOUR_12H   7
`define RRSA_HOUR_PM    6
// ==========================================================
// time base rates in hertz
`define RRSA_TB_HZ      32768
`define RRSA_HUND_HZ    100
`endif

// ==== pkg/rrsa_pkg.sv ====
/*
 Types of the serial RTC memory front end.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rrsa_pkg;
	// memory request carried across the clock crossing
	typedef struct packed {
		logic       we;
		logic       snap;
		logic [7:0] addr;
		logic [7:0] data;
	} rrsa_req_t;
	// counter locations 1 to 7, BCD
	typedef struct packed {
		logic [7:0] hund;
		logic [7:0] sec;
		logic [7:0] mins;
		logic [7:0] hour;
		logic [7:0] date;
		logic [7:0] wmon;
		logic [7:0] timer;
	} rrsa_time_t;
	typedef enum logic [4:0] {
		st_idle = 5'h01,
		st_rx   = 5'h02,
		st_ack  = 5'h04,
		st_tx   = 5'h08,
		st_rack = 5'h10
	} rrsa_state_t;
	typedef enum logic [2:0] {
		k_slave = 3'h1,
		k_word  = 3'h2,
		k_data  = 3'h4
	} rrsa_kind_t;
endpackage
`default_nettype wire

// ==== verilog/rrsa_ram.sv ====
/*
 Byte-wide static memory with registered read data, read before write.
 Assumes a single clock and a synchronous active-low reset.
*/
`include "rrsa_defs.svh"
`default_nettype none
module rrsa_ram #(
	parameter int DEPTH = `RRSA_MEM_DEPTH,
	parameter int AW    = 8,
	parameter int DW    = 8
) (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [DEPTH];

	// ==========================================================
	// storage
	always_ff @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// read data register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end

	property p_ram_hold;
		@(posedge clock) disable iff (!rst_b)
		we ##1 (!we && addr == $past(addr)) |=> rdata == $past(wdata, 2);
	endproperty
	a_ram_hold: assert property (p_ram_hold) else $error("ram lost a byte");
endmodule
`default_nettype wire

// ==== verilog/rrsa_clock.sv ====
/*
 Clock and calendar counters at locations 1 to 7, BCD, with time base prescaler.
 Assumes tick_in is a one-cycle pulse per time base edge, already synchronised.
*/
`include "rrsa_defs.svh"
`default_nettype none
module rrsa_clock #(
	parameter int TB_HZ = `RRSA_TB_HZ
) (
	input  wire logic           clock,
	input  wire logic           rst_b,
	input  wire logic           tick_in,
	input  wire logic [7:0]     ctrl,
	input  wire logic           wr_en,
	input  wire logic [2:0]     wr_idx,
	input  wire logic [7:0]     wr_data,
	output rrsa_pkg::rrsa_time_t tm,
	output logic                timer_ovf
);
	rrsa_pkg::rrsa_time_t tm_next;
	logic [15:0] acc_reg;
	logic [15:0] acc_sum;
	logic        run;
	logic        step2;
	logic        hund_tick;
	logic        c_sec;
	logic        c_min;
	logic        c_hr;
	logic        c_day;
	logic [7:0]  h1;
	logic [7:0]  hr;
	logic [7:0]  d;
	logic [7:0]  mo;
	logic [1:0]  yr;
	logic        pm;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lim,
		input logic [7:0] lo);
		if (v == lim) return lo;
		if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
		return v + 8'h01;
	endfunction

	function automatic logic [7:0] days_in(input logic [7:0] m, input logic [1:0] y);
		case (m)
			8'h02: return (y == 2'h0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// ==========================================================
	// time base: fractional divide to hundredths, or 50 Hz steps of two
	assign run       = !ctrl[`RRSA_CB_STOP] && !ctrl[`RRSA_CB_MODE_HI];
	assign step2     = ctrl[`RRSA_CB_MODE_LO];
	assign acc_sum   = acc_reg + 16'(`RRSA_HUND_HZ);
	assign hund_tick = tick_in && run && (step2 || acc_sum >= 16'(TB_HZ));

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			acc_reg <= 16'h0000;
		end else if (tick_in && run && !step2) begin
			acc_reg <= (acc_sum >= 16'(TB_HZ)) ? acc_sum - 16'(TB_HZ) : acc_sum;
		end
	end

	// carry chain, then software writes win per location
	always_comb begin
		tm_next   = tm;
		timer_ovf = 1'b0;
		c_sec     = 1'b0;
		c_min     = 1'b0;
		c_hr      = 1'b0;
		c_day     = 1'b0;
		h1        = bcd_inc(tm.hund, 8'h99, 8'h00);
		hr        = {2'b00, tm.hour[5:0]};
		pm        = tm.hour[`RRSA_HOUR_PM];
		d         = {2'b00, tm.date[5:0]};
		mo        = {3'b000, tm.wmon[4:0]};
		yr        = tm.date[7:6];
		if (hund_tick) begin
			tm_next.hund = step2 ? bcd_inc(h1, 8'h99, 8'h00) : h1;
			c_sec = (tm.hund == 8'h99) || (step2 && h1 == 8'h99);
		end
		if (c_sec) begin
			tm_next.sec = bcd_inc(tm.sec, 8'h59, 8'h00);
			c_min = tm.sec == 8'h59;
		end
		if (c_min) begin
			tm_next.mins = bcd_inc(tm.mins, 8'h59, 8'h00);
			c_hr = tm.mins == 8'h59;
		end
		if (c_hr) begin
			if (!tm.hour[`RRSA_HOUR_12H]) begin
				c_day = hr == 8'h23;
				hr = bcd_inc(hr, 8'h23, 8'h00);
			end else if (hr == 8'h11) begin
				c_day = pm;
				pm = !pm;
				hr = 8'h12;
			end else begin
				hr = bcd_inc(hr, 8'h12, 8'h01);
			end
			tm_next.hour = {tm.hour[`RRSA_HOUR_12H], pm, hr[5:0]};
		end
		if (c_day) begin
			tm_next.wmon[7:5] = (tm.wmon[7:5] == 3'h6) ? 3'h0 : tm.wmon[7:5] + 3'h1;
			timer_ovf = tm.timer == 8'h99;
			tm_next.timer = bcd_inc(tm.timer, 8'h99, 8'h00);
			if (d == days_in(mo, yr)) begin
				d = 8'h01;
				if (mo == 8'h12) begin
					mo = 8'h01;
					yr = yr + 2'h1;
				end else begin
					mo = bcd_inc(mo, 8'h12, 8'h01);
				end
			end else begin
				d = bcd_inc(d, 8'h31, 8'h01);
			end
			tm_next.date = {yr, d[5:0]};
			tm_next.wmon[4:0] = mo[4:0];
		end
		if (wr_en) begin
			case (wr_idx)
				3'h1: tm_next.hund = wr_data;
				3'h2: tm_next.sec = wr_data;
				3'h3: tm_next.mins = wr_data;
				3'h4: tm_next.hour = wr_data;
				3'h5: tm_next.date = wr_data;
				3'h6: tm_next.wmon = wr_data;
				3'h7: tm_next.timer = wr_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			tm <= '0;
		end else begin
			tm <= tm_next;
		end
	end

	property p_hour24;
		@(posedge clock) disable iff (!rst_b)
		(c_hr && !tm.hour[7] && tm.hour[5:0] == 6'h23 && !wr_en)
		|=> tm.hour[5:0] == 6'h00 && tm.date != $past(tm.date);
	endproperty
	a_hour24: assert property (p_hour24) else $error("24h wrap wrong");

	property p_leap;
		@(posedge clock) disable iff (!rst_b)
		(c_day && tm.wmon[4:0] == 5'h02 && tm.date == 8'h28 && !wr_en) |=> tm.date == 8'h29;
	endproperty
	a_leap: assert property (p_leap) else $error("leap day skipped");

	property p_fifty;
		@(posedge clock) disable iff (!rst_b)
		(hund_tick && step2 && tm.hund == 8'h10 && !wr_en) |=> tm.hund == 8'h12;
	endproperty
	a_fifty: assert property (p_fifty) else $error("50 Hz step wrong");
endmodule
`default_nettype wire

// ==== verilog/rrsa_top.sv ====
/*
 Serial-bus slave front end of a clock/calendar with 256 bytes of memory.
 Bus engine runs on link_clk and oversamples the bus pins; memory, control
 and counters run on clock. Assumes link_clk is far faster than the bus.
*/
// Function
// - memory holds 256 bytes reached by one byte-wide word address.
// - word address steps by one after every data byte written or read.
// - select pin picks slave address A0/A1 or A2/A3 (write/read).
// - locations 0 to 7 carry control and the clock counters.
// - locations 8 to 15 are plain storage; control bit 2 only drives alarm_area_en.
// - locations 16 to 255 keep whatever was last written.
// - hours count in 24 h or 12 h form, chosen by configuration.
// - time base is 32.768 kHz or 50 Hz.
// - calendar follows a four-year cycle for leap years.
// - location 0 is the control and status register.
// - with alarm enable bit 2 clear the alarm area is free storage.
// - reading a counter freezes all counters into holding latches first.
`include "rrsa_defs.svh"
`default_nettype none
module rrsa_top #(
	parameter int TB_HZ = `RRSA_TB_HZ
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic link_clk,
	input  wire logic scl_in,
	input  wire logic sda_in,
	input  wire logic address_select_pin,
	input  wire logic timebase_in,
	output logic      sda_out,
	output logic      sda_oe,
	output logic      alarm_area_en
);
	// link domain
	logic [1:0]              lrst_sync_reg;
	logic                    lrst_b;
	logic [2:0]              scl_sh_reg;
	logic [2:0]              sda_sh_reg;
	logic [1:0]              asel_sh_reg;
	logic                    scl_s;
	logic                    sda_s;
	logic                    asel_s;
	logic                    scl_rise;
	logic                    scl_fall;
	logic                    start_c;
	logic                    stop_c;
	rrsa_pkg::rrsa_state_t   st_reg;
	rrsa_pkg::rrsa_kind_t    kind_reg;
	logic [2:0]              bit_reg;
	logic [7:0]              sh_reg;
	logic                    done_reg;
	logic                    rd_mode_reg;
	logic                    nack_reg;
	logic [7:0]              addr_reg;
	logic                    byte_end;
	logic                    adr_hit;
	logic                    take;
	logic                    load;
	logic                    rd_issue;
	logic                    wr_issue;
	rrsa_pkg::rrsa_req_t     req_reg;
	logic                    req_tgl_reg;
	logic [2:0]              ack_sh_reg;
	logic [7:0]              rd_link_reg;
	// core domain
	logic [2:0]              rq_sh_reg;
	logic [2:0]              tb_sh_reg;
	logic                    rq_new;
	logic                    tb_edge;
	logic                    ph1_reg;
	logic [7:0]              ad1_reg;
	logic [7:0]              ctrl_reg;
	logic [7:0]              core_rd_reg;
	logic                    ack_tgl_reg;
	logic                    ram_we;
	logic [7:0]              ram_rd;
	logic                    cnt_wr;
	logic                    timer_ovf;
	rrsa_pkg::rrsa_time_t    tm;
	rrsa_pkg::rrsa_time_t    cap_reg;

	// counter byte by location, year and weekday hidden under mask
	function automatic logic [7:0] cnt_sel(input rrsa_pkg::rrsa_time_t t, input logic [2:0] i,
		input logic mask);
		case (i)
			3'h1: return t.hund;
			3'h2: return t.sec;
			3'h3: return t.mins;
			3'h4: return t.hour;
			3'h5: return mask ? {2'b00, t.date[5:0]} : t.date;
			3'h6: return mask ? {3'b000, t.wmon[4:0]} : t.wmon;
			3'h7: return t.timer;
			default: return 8'h00;
		endcase
	endfunction

	// ==========================================================
	// link side: reset and pin synchronisers
	always_ff @(posedge link_clk) begin
		lrst_sync_reg <= {lrst_sync_reg[0], rst_b};
	end
	assign lrst_b = lrst_sync_reg[1];

	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			scl_sh_reg  <= 3'h7;
			sda_sh_reg  <= 3'h7;
			asel_sh_reg <= 2'h0;
		end else begin
			scl_sh_reg  <= {scl_sh_reg[1:0], scl_in};
			sda_sh_reg  <= {sda_sh_reg[1:0], sda_in};
			asel_sh_reg <= {asel_sh_reg[0], address_select_pin};
		end
	end

	// bus events from the second and third stages
	assign scl_s    = scl_sh_reg[1];
	assign sda_s    = sda_sh_reg[1];
	assign asel_s   = asel_sh_reg[1];
	assign scl_rise = scl_s && !scl_sh_reg[2];
	assign scl_fall = !scl_s && scl_sh_reg[2];
	assign start_c  = scl_s && scl_sh_reg[2] && sda_sh_reg[2] && !sda_s;
	assign stop_c   = scl_s && scl_sh_reg[2] && !sda_sh_reg[2] && sda_s;

	// byte decisions
	assign byte_end = st_reg == rrsa_pkg::st_rx && done_reg && scl_fall;
	assign adr_hit  = sh_reg[7:2] == `RRSA_SLV_BASE && sh_reg[1] == asel_s;
	assign take     = byte_end && (kind_reg != rrsa_pkg::k_slave || adr_hit);
	assign load     = scl_fall && ((st_reg == rrsa_pkg::st_ack && rd_mode_reg)
		|| (st_reg == rrsa_pkg::st_rack && !nack_reg));
	assign rd_issue = (take && kind_reg == rrsa_pkg::k_slave && sh_reg[0]) || load;
	assign wr_issue = take && kind_reg == rrsa_pkg::k_data;

	// ==========================================================
	// bus protocol state machine
	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			st_reg      <= rrsa_pkg::st_idle;
			kind_reg    <= rrsa_pkg::k_slave;
			bit_reg     <= 3'h0;
			sh_reg      <= 8'h00;
			done_reg    <= 1'b0;
			rd_mode_reg <= 1'b0;
			nack_reg    <= 1'b1;
			sda_oe      <= 1'b0;
		end else if (start_c) begin
			st_reg      <= rrsa_pkg::st_rx;
			kind_reg    <= rrsa_pkg::k_slave;
			bit_reg     <= 3'h0;
			done_reg    <= 1'b0;
			rd_mode_reg <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (stop_c) begin
			st_reg <= rrsa_pkg::st_idle;
			sda_oe <= 1'b0;
		end else begin
			unique case (st_reg)
				rrsa_pkg::st_idle: ;
				rrsa_pkg::st_rx: begin
					if (scl_rise) begin
						sh_reg   <= {sh_reg[6:0], sda_s};
						bit_reg  <= bit_reg + 3'h1;
						done_reg <= bit_reg == 3'h7;
					end else if (byte_end) begin
						done_reg <= 1'b0;
						if (take) begin
							st_reg <= rrsa_pkg::st_ack;
							sda_oe <= 1'b1;
							if (kind_reg == rrsa_pkg::k_slave) begin
								rd_mode_reg <= sh_reg[0];
								kind_reg    <= rrsa_pkg::k_word;
							end else begin
								kind_reg <= rrsa_pkg::k_data;
							end
						end else begin
							st_reg <= rrsa_pkg::st_idle;
						end
					end
				end
				rrsa_pkg::st_ack: begin
					if (scl_fall) begin
						bit_reg <= 3'h0;
						if (rd_mode_reg) begin
							st_reg <= rrsa_pkg::st_tx;
							sh_reg <= rd_link_reg;
							sda_oe <= !rd_link_reg[7];
						end else begin
							st_reg <= rrsa_pkg::st_rx;
							sda_oe <= 1'b0;
						end
					end
				end
				rrsa_pkg::st_tx: begin
					if (scl_fall) begin
						if (bit_reg == 3'h7) begin
							st_reg <= rrsa_pkg::st_rack;
							sda_oe <= 1'b0;
						end else begin
							bit_reg <= bit_reg + 3'h1;
							sh_reg  <= {sh_reg[6:0], 1'b0};
							sda_oe  <= !sh_reg[6];
						end
					end
				end
				rrsa_pkg::st_rack: begin
					if (scl_rise) begin
						nack_reg <= sda_s;
					end else if (scl_fall) begin
						if (!nack_reg) begin
							st_reg  <= rrsa_pkg::st_tx;
							bit_reg <= 3'h0;
							sh_reg  <= rd_link_reg;
							sda_oe  <= !rd_link_reg[7];
						end else begin
							st_reg <= rrsa_pkg::st_idle;
						end
					end
				end
				default: st_reg <= rrsa_pkg::st_idle;
			endcase
		end
	end

	// open-drain data pin only ever pulls low
	always_ff @(posedge link_clk) begin
		sda_out <= 1'b0;
	end

	// word address: loaded by the word byte, stepped after each data byte
	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			addr_reg <= 8'h00;
		end else if (take && kind_reg == rrsa_pkg::k_word) begin
			addr_reg <= sh_reg;
		end else if (wr_issue || load) begin
			addr_reg <= addr_reg + 8'h01;
		end
	end

	// ==========================================================
	// request toggle toward the core, payload held until answered
	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			req_reg     <= '0;
			req_tgl_reg <= 1'b0;
		end else if (rd_issue || wr_issue) begin
			req_reg.we   <= wr_issue;
			req_reg.snap <= take && kind_reg == rrsa_pkg::k_slave;
			req_reg.addr <= load ? addr_reg + 8'h01 : addr_reg;
			req_reg.data <= sh_reg;
			req_tgl_reg  <= !req_tgl_reg;
		end
	end

	// answer toggle back from the core, read byte caught on its change
	always_ff @(posedge link_clk) begin
		if (!lrst_b) begin
			ack_sh_reg  <= 3'h0;
			rd_link_reg <= 8'h00;
		end else begin
			ack_sh_reg <= {ack_sh_reg[1:0], ack_tgl_reg};
			if (ack_sh_reg[2] != ack_sh_reg[1]) begin
				rd_link_reg <= core_rd_reg;
			end
		end
	end

	// ==========================================================
	// core side: synchronisers for request toggle and time base pin
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rq_sh_reg <= 3'h0;
			tb_sh_reg <= 3'h0;
		end else begin
			rq_sh_reg <= {rq_sh_reg[1:0], req_tgl_reg};
			tb_sh_reg <= {tb_sh_reg[1:0], timebase_in};
		end
	end
	assign rq_new  = rq_sh_reg[2] != rq_sh_reg[1];
	assign tb_edge = tb_sh_reg[1] && !tb_sh_reg[2];

	// every location is backed by memory; counters shadow 1 to 7
	assign ram_we = rq_new && req_reg.we;
	assign cnt_wr = ram_we && req_reg.addr != `RRSA_CTRL_ADDR
		&& req_reg.addr <= `RRSA_CNT_TOP;

	rrsa_ram #(
		.DEPTH (`RRSA_MEM_DEPTH),
		.AW    (8),
		.DW    (8)
	) u_ram (
		.clock (clock),
		.rst_b (rst_b),
		.we    (ram_we),
		.addr  (req_reg.addr),
		.wdata (req_reg.data),
		.rdata (ram_rd)
	);

	rrsa_clock #(
		.TB_HZ (TB_HZ)
	) u_clock (
		.clock     (clock),
		.rst_b     (rst_b),
		.tick_in   (tb_edge),
		.ctrl      (ctrl_reg),
		.wr_en     (cnt_wr),
		.wr_idx    (req_reg.addr[2:0]),
		.wr_data   (req_reg.data),
		.tm        (tm),
		.timer_ovf (timer_ovf)
	);

	// control and status: written at location 0, overflow flag set wins
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ctrl_reg <= `RRSA_CTRL_RST;
		end else begin
			if (ram_we && req_reg.addr == `RRSA_CTRL_ADDR) begin
				ctrl_reg <= req_reg.data;
			end
			if (timer_ovf) begin
				ctrl_reg[`RRSA_CB_TFLAG] <= 1'b1;
			end
		end
	end
	assign alarm_area_en = ctrl_reg[`RRSA_CB_ALARM];

	// holding latches frozen at the start of a read cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cap_reg <= '0;
		end else if (rq_new && req_reg.snap) begin
			cap_reg <= tm;
		end
	end

	// answer one cycle after the request, read byte from its source
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ph1_reg     <= 1'b0;
			ad1_reg     <= 8'h00;
			core_rd_reg <= 8'h00;
			ack_tgl_reg <= 1'b0;
		end else begin
			ph1_reg <= rq_new;
			ad1_reg <= req_reg.addr;
			if (ph1_reg) begin
				ack_tgl_reg <= !ack_tgl_reg;
				if (ad1_reg == `RRSA_CTRL_ADDR) begin
					core_rd_reg <= ctrl_reg;
				end else if (ad1_reg <= `RRSA_CNT_TOP) begin
					core_rd_reg <= cnt_sel(cap_reg, ad1_reg[2:0], ctrl_reg[`RRSA_CB_MASK]);
				end else begin
					core_rd_reg <= ram_rd;
				end
			end
		end
	end

	// ==========================================================
	// checks
	property p_slave_ack;
		@(posedge link_clk) disable iff (!lrst_b)
		(byte_end && kind_reg == rrsa_pkg::k_slave) |=> sda_oe == (sh_reg[7:2] == 6'h28
			&& $past(sh_reg[1]) == $past(asel_s));
	endproperty
	a_slave_ack: assert property (p_slave_ack) else $error("address ack wrong");

	property p_data_ack;
		@(posedge link_clk) disable iff (!lrst_b)
		(byte_end && kind_reg == rrsa_pkg::k_data) |=> sda_oe ##1 sda_oe[*2];
	endproperty
	a_data_ack: assert property (p_data_ack) else $error("data byte not acked");

	property p_addr_inc;
		@(posedge link_clk) disable iff (!lrst_b)
		(wr_issue || load) |=> addr_reg == $past(addr_reg) + 8'h01;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("address not stepped");

	property p_wrap;
		@(posedge link_clk) disable iff (!lrst_b)
		(load && addr_reg == 8'hff) |=> addr_reg == 8'h00 && req_reg.addr == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("address did not wrap");

	property p_capture;
		@(posedge clock) disable iff (!rst_b)
		(rq_new && req_reg.snap) |=> cap_reg == $past(tm);
	endproperty
	a_capture: assert property (p_capture) else $error("counters not frozen");

	property p_ctrl_wr;
		@(posedge clock) disable iff (!rst_b)
		(ram_we && req_reg.addr == 8'h00 && !timer_ovf) |=> ctrl_reg == $past(req_reg.data);
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

	property p_alarm_area;
		@(posedge clock) disable iff (!rst_b)
		(ram_we && req_reg.addr == 8'h00) |=> alarm_area_en == $past(req_reg.data[2]);
	endproperty
	a_alarm_area: assert property (p_alarm_area) else $error("alarm area wrong");

	property p_free_read;
		@(posedge clock) disable iff (!rst_b)
		(rq_new && req_reg.addr >= 8'h08) ##1 1'b1 |=> core_rd_reg == $past(ram_rd);
	endproperty
	a_free_read: assert property (p_free_read) else $error("free byte misread");

	c_read_more: cover property (@(posedge link_clk) disable iff (!lrst_b)
		st_reg == rrsa_pkg::st_rack && scl_fall && !nack_reg);
	c_write: cover property (@(posedge link_clk) disable iff (!lrst_b) wr_issue);
	c_snap: cover property (@(posedge clock) disable iff (!rst_b) rq_new && req_reg.snap);
endmodule
`default_nettype wire

// ==== test/rrsa_master.sv ====
/*
 Serial bus master model: drives bus clock and data, reads the line back.
 Assumes the device pulls data low while sda_oe is high; pull-up otherwise.
*/
`default_nettype none
module rrsa_master (
	input  wire logic clock,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_m,
	output wire logic sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// line and bit timing
	localparam int HALF = 200; // 2 us per clock phase
	assign sda_line = sda_m & !sda_oe; // pull-up unless pulled low
	// idle bus at time zero
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask
	// data moves only while clock low, sampled mid high
	task automatic bit_io(input logic b, output logic r);
		hold(10);
		sda_m <= b;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF / 2);
		r = sda_line;
		hold(HALF / 2);
		scl <= 1'b0;
	endtask
	// start and repeated start: data falls with clock high
	task automatic start();
		hold(10);
		sda_m <= 1'b1;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		sda_m <= 1'b0;
		hold(HALF);
		scl <= 1'b0;
	endtask
	// stop: data rises with clock high
	task automatic stop();
		hold(10);
		sda_m <= 1'b0;
		hold(HALF);
		scl <= 1'b1;
		hold(HALF);
		sda_m <= 1'b1;
		hold(HALF);
	endtask
	// msb first, then release for the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic nak, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(nak, r);
	endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
/*
 Self-checking bench: master model against a byte-array model of memory.
 Assumes the top module with its assertions inside the design files.
*/
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// clocks, design and master
	logic       clock, link_clk, rst_b, sel, tb_in, scl, sda_m, oe, so, aen, a;
	wire logic  sda_line;
	logic [7:0] mem [256];
	logic [7:0] d, x, y, h;
	int         miscompares, total_checks, wa, k, hv;
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #62.5 link_clk = ~link_clk;
	end
	rrsa_top #(.TB_HZ(100)) dut_u (.clock(clock), .rst_b(rst_b), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda_line), .address_select_pin(sel), .timebase_in(tb_in),
		.sda_out(so), .sda_oe(oe), .alarm_area_en(aen));
	rrsa_master m_u (.clock(clock), .sda_oe(oe), .scl(scl), .sda_m(sda_m),
		.sda_line(sda_line));
	// ==========================================================
	// compares and closing
	task automatic chk_bit(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic send(input logic [7:0] v, input logic e);
		m_u.wbyte(v, a);
		chk_bit("ack", e, a);
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		end_of_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		sel = 1'b0;
		tb_in = 1'b0;
		void'($urandom(32'hbb540a23));
		repeat (50) @(posedge clock);
		rst_b <= 1'b1;
		m_u.hold(100);
		chk_bit("area_en", 1'b0, aen);
		chk_bit("sda_out", 1'b0, so);
		// write top location, wrap into control, then hundredths
		x = $urandom;
		y = ($urandom & 8'h18) | 8'h04;
		h = {4'($urandom_range(9)), 4'($urandom_range(9))};
		k = 1 + $urandom_range(19);
		m_u.start();
		send(8'ha0, 1'b1);
		send(8'hff, 1'b1);
		send(x, 1'b1);
		send(y, 1'b1);
		send(h, 1'b1);
		m_u.stop();
		mem[255] = x;
		mem[0] = y;
		chk_bit("area_en", 1'b1, aen);
		// time base edges: one hundredth each, two in 50 Hz mode
		hv = (10 * h[7:4] + h[3:0] + k * (y[4] ? 2 : 1)) % 100;
		repeat (k) begin
			tb_in <= 1'b1;
			m_u.hold(2);
			tb_in <= 1'b0;
			m_u.hold(2);
		end
		// read back across the wrap with repeated start
		m_u.start();
		send(8'ha0, 1'b1);
		send(8'hff, 1'b1);
		m_u.start();
		send(8'ha1, 1'b1);
		m_u.rbyte(1'b0, d);
		chk_byte("rd_top", mem[255], d);
		m_u.rbyte(1'b0, d);
		chk_byte("rd_ctrl", mem[0], d);
		m_u.rbyte(1'b1, d);
		chk_byte("rd_hund", 8'((hv / 10) * 16 + hv % 10), d);
		m_u.stop();
		// other slave address ignored for each select level
		for (int s = 0; s < 2; s++) begin
			sel <= s[0];
			m_u.hold(100);
			m_u.start();
			send(s[0] ? 8'ha0 : 8'ha2, 1'b0);
			m_u.stop();
		end
		// free area write and read at the second address
		wa = 16 + $urandom_range(238);
		m_u.start();
		send(8'ha2, 1'b1);
		send(wa[7:0], 1'b1);
		for (int i = 0; i < 2; i++) begin
			x = $urandom;
			mem[wa + i] = x;
			send(x, 1'b1);
		end
		m_u.stop();
		m_u.start();
		send(8'ha2, 1'b1);
		send(wa[7:0], 1'b1);
		m_u.start();
		send(8'ha3, 1'b1);
		m_u.rbyte(1'b0, d);
		chk_byte("rd_free0", mem[wa], d);
		m_u.rbyte(1'b1, d);
		chk_byte("rd_free1", mem[wa + 1], d);
		m_u.stop();
		end_of_test();
	end
endmodule
`default_nettype wire
